// ### hdl/flash_self_program_control.sv
// Purpose: Arms and runs flash self-programming commands from the core
// Assumes: Core strobes, fuses and flash macro share clk_sys
// Notes: Control register at APB offset 0x00, zero wait states
//
// The APB slave port and the register offsets were decided locally.

`timescale 1ns/1ns

module flash_self_program_control
  import flash_self_program_pkg::*;
#(
  parameter int PAGE_WORD_BITS = 6,
  parameter int RWW_PAGE_COUNT = 224,
  parameter logic [15:0] BOOT_START_WORD = 16'h3800
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core side
  input wire logic spmStrobe,
  input wire logic lpmStrobe,
  input wire logic [15:0] zPointer,
  input wire logic [15:0] wordData,
  input wire logic globalIntEnable,
  output logic [7:0] lpmData,
  output logic lpmValid,
  output logic cpuHalt,
  output logic readyIrq,
  output logic sectionBusy,
  output logic [15:0] resetVector,
  // Fuses and lock bits
  input wire logic bootVectorFuse,
  input wire logic [7:0] fuseLow,
  input wire logic [7:0] fuseHigh,
  input wire logic [7:0] fuseExt,
  input wire logic [7:0] lockBits,
  output logic lockProgram,
  output logic [7:0] lockData,
  // EEPROM interlock
  input wire logic eepromBusy,
  // Flash macro
  input wire logic flashDone,
  output logic flashErase,
  output logic flashWrite,
  output logic [14-PAGE_WORD_BITS:0] flashPage,
  input wire logic [PAGE_WORD_BITS-1:0] bufReadAddr,
  output logic [15:0] bufReadData
);

  // ----------------------------------------
  // Sizes and helpers
  // ----------------------------------------
  localparam int PAGE_BITS = 15 - PAGE_WORD_BITS;
  localparam int PAGE_WORDS = 1 << PAGE_WORD_BITS;
  localparam logic [PAGE_BITS-1:0] RWW_LIMIT = PAGE_BITS'(RWW_PAGE_COUNT);

  function automatic logic isValidCode(input logic [4:0] code);
    isValidCode = (code == CODE_REENABLE) || (code == CODE_LOCKSET) ||
                  (code == CODE_WRITE) || (code == CODE_ERASE) || (code == CODE_LOAD);
  endfunction : isValidCode

  function automatic logic [PAGE_BITS-1:0] pageOf(input logic [15:0] z);
    pageOf = z[15:PAGE_WORD_BITS+1];
  endfunction : pageOf

  function automatic logic inRww(input logic [PAGE_BITS-1:0] page);
    inRww = page < RWW_LIMIT;
  endfunction : inRww

  // ----------------------------------------
  // State
  // ----------------------------------------
  seq_state_t state_reg, state_next;
  logic [4:0] cmd_reg, cmd_next;
  logic ie_reg, ie_next;
  logic busy_reg, busy_next;
  logic halt_reg, halt_next;
  logic [2:0] armCnt_reg, armCnt_next;
  logic [PAGE_BITS-1:0] page_reg, page_next;
  logic [PAGE_WORDS-1:0] bufValid_reg, bufValid_next;
  logic [15:0] bufMem [PAGE_WORDS];
  logic bufWrite;
  logic [PAGE_WORD_BITS-1:0] bufWrIdx;
  logic eraseNext, writeNext, lockNext;
  logic [7:0] lockData_next;
  logic lpmValidNext;
  logic [7:0] lpmData_next;
  logic apbSetup, ctrlHit, ctrlWrite;
  logic [7:0] ctrlView;
  logic [31:0] prdata_next;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  assign apbSetup = psel && !penable;
  assign ctrlHit = (paddr == CTRL_OFFSET);
  assign ctrlWrite = psel && penable && pready && pwrite && ctrlHit;
  assign ctrlView = {ie_reg, busy_reg, 1'b0, cmd_reg};
  assign bufWrIdx = zPointer[PAGE_WORD_BITS:1];

  always_comb begin
    prdata_next = prdata;
    if (apbSetup) begin
      prdata_next = (ctrlHit && !pwrite) ? {24'h000000, ctrlView} : 32'h00000000;
    end
  end

  // ----------------------------------------
  // Command sequencer
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    cmd_next = cmd_reg;
    ie_next = ie_reg;
    busy_next = busy_reg;
    halt_next = halt_reg;
    armCnt_next = armCnt_reg;
    page_next = page_reg;
    bufValid_next = bufValid_reg;
    bufWrite = 1'b0;
    eraseNext = 1'b0;
    writeNext = 1'b0;
    lockNext = 1'b0;
    lockData_next = lockData;
    lpmValidNext = 1'b0;
    lpmData_next = lpmData;
    if (ctrlWrite) begin
      ie_next = pwdata[IE_BIT];
    end
    case (state_reg)
      ST_IDLE, ST_ARMED: begin
        if (ctrlWrite) begin
          if (pwdata[REEN_BIT]) begin
            bufValid_next = '0;
          end
          if (!eepromBusy && isValidCode(pwdata[4:0])) begin
            cmd_next = pwdata[4:0];
            armCnt_next = 3'h0;
            state_next = ST_ARMED;
          end else if (state_reg == ST_ARMED) begin
            cmd_next = CODE_NONE;
            state_next = ST_IDLE;
          end
        end else if (state_reg == ST_ARMED) begin
          if (spmStrobe && !eepromBusy) begin
            case (cmd_reg)
              CODE_LOAD: begin
                bufWrite = 1'b1;
                bufValid_next[bufWrIdx] = 1'b1;
                busy_next = 1'b0;
                cmd_next = CODE_NONE;
                state_next = ST_IDLE;
              end
              CODE_ERASE, CODE_WRITE: begin
                page_next = pageOf(zPointer);
                if (inRww(pageOf(zPointer))) begin
                  busy_next = 1'b1;
                end else begin
                  halt_next = 1'b1;
                end
                eraseNext = (cmd_reg == CODE_ERASE);
                writeNext = (cmd_reg == CODE_WRITE);
                state_next = ST_BUSY;
              end
              CODE_LOCKSET: begin
                lockNext = 1'b1;
                lockData_next = wordData[7:0];
                state_next = ST_BUSY;
              end
              CODE_REENABLE: begin
                busy_next = 1'b0;
                bufValid_next = '0;
                cmd_next = CODE_NONE;
                state_next = ST_IDLE;
              end
              default: begin
                cmd_next = CODE_NONE;
                state_next = ST_IDLE;
              end
            endcase
          end else if (lpmStrobe && cmd_reg == CODE_LOCKSET && armCnt_reg < LPM_WINDOW_CYC) begin
            if (!eepromBusy) begin
              lpmValidNext = 1'b1;
              case (zPointer[1:0])
                ZSEL_LOCK: lpmData_next = lockBits;
                ZSEL_FUSE_EXT: lpmData_next = fuseExt;
                ZSEL_FUSE_HIGH: lpmData_next = fuseHigh;
                default: lpmData_next = fuseLow;
              endcase
            end
            cmd_next = CODE_NONE;
            state_next = ST_IDLE;
          end else if (armCnt_reg == ARM_WINDOW_CYC - 3'h1) begin
            cmd_next = CODE_NONE;
            state_next = ST_IDLE;
          end else begin
            armCnt_next = armCnt_reg + 3'h1;
          end
        end
      end
      ST_BUSY: begin
        // Control writes only reach the interrupt enable bit here
        if (flashDone) begin
          if (cmd_reg == CODE_WRITE) begin
            bufValid_next = '0;
          end
          cmd_next = CODE_NONE;
          halt_next = 1'b0;
          state_next = ST_IDLE;
        end
      end
      default: begin
        cmd_next = CODE_NONE;
        state_next = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_reg <= ST_IDLE;
      cmd_reg <= CTRL_RESET[4:0];
      ie_reg <= CTRL_RESET[IE_BIT];
      busy_reg <= CTRL_RESET[BUSY_BIT];
      halt_reg <= 1'b0;
      armCnt_reg <= 3'h0;
      page_reg <= '0;
      bufValid_reg <= '0;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      lpmData <= 8'h00;
      lpmValid <= 1'b0;
      cpuHalt <= 1'b0;
      readyIrq <= 1'b0;
      sectionBusy <= 1'b0;
      resetVector <= APP_RESET_VECTOR;
      lockProgram <= 1'b0;
      lockData <= 8'h00;
      flashErase <= 1'b0;
      flashWrite <= 1'b0;
      flashPage <= '0;
    end else begin
      state_reg <= state_next;
      cmd_reg <= cmd_next;
      ie_reg <= ie_next;
      busy_reg <= busy_next;
      halt_reg <= halt_next;
      armCnt_reg <= armCnt_next;
      page_reg <= page_next;
      bufValid_reg <= bufValid_next;
      prdata <= prdata_next;
      pready <= apbSetup;
      pslverr <= apbSetup && !ctrlHit;
      lpmData <= lpmData_next;
      lpmValid <= lpmValidNext;
      cpuHalt <= halt_next;
      readyIrq <= ie_next && globalIntEnable && !cmd_next[EN_BIT];
      sectionBusy <= busy_next;
      // Fuse is an input only; nothing here can alter it
      resetVector <= bootVectorFuse ? APP_RESET_VECTOR : BOOT_START_WORD;
      lockProgram <= lockNext;
      lockData <= lockData_next;
      flashErase <= eraseNext;
      flashWrite <= writeNext;
      flashPage <= page_next;
    end
  end

  // ----------------------------------------
  // Page buffer storage
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (bufWrite) begin
      bufMem[bufWrIdx] <= wordData;
    end
    bufReadData <= bufValid_reg[bufReadAddr] ? bufMem[bufReadAddr] : ERASED_WORD;
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  logic quietArmed;
  assign quietArmed = (state_reg == ST_ARMED) && !spmStrobe && !lpmStrobe && !ctrlWrite;

  sequence armQuiet4;
    (quietArmed && armCnt_reg == 3'h0) ##1 quietArmed [*3];
  endsequence

  sequence storeOp(logic [4:0] code);
    state_reg == ST_ARMED && !ctrlWrite && spmStrobe && !eepromBusy && cmd_reg == code;
  endsequence

  chk_reserved_zero: assert property (pready && !pwrite |-> !prdata[RES_BIT])
    else $error("reserved bit read as one");

  chk_irq_follow: assert property (state_reg == ST_IDLE && ie_reg && globalIntEnable [*2] |-> readyIrq)
    else $error("ready interrupt missing while idle");

  chk_arm_expiry: assert property (armQuiet4 |=> cmd_reg == CODE_NONE && state_reg == ST_IDLE)
    else $error("command bits outlived window");

  chk_busy_rww: assert property (storeOp(CODE_ERASE) and inRww(pageOf(zPointer)) |=> sectionBusy && !cpuHalt)
    else $error("rww erase did not set busy");

  chk_halt_halting_section: assert property (storeOp(CODE_WRITE) and !inRww(pageOf(zPointer))
                                  |=> cpuHalt throughout (state_reg == ST_BUSY) [*2])
    else $error("core not halted on halting section write");

  chk_load_unbusy: assert property (storeOp(CODE_LOAD) |=> !sectionBusy && bufValid_reg[$past(bufWrIdx)])
    else $error("load did not clear busy");

  chk_busy_hold: assert property (state_reg == ST_BUSY && !flashDone |=> $stable(cmd_reg) && $stable(flashPage))
    else $error("running operation disturbed");

  chk_bad_code: assert property (state_reg == ST_IDLE && ctrlWrite && !isValidCode(pwdata[4:0])
                                 |=> state_reg == ST_IDLE && cmd_reg == CODE_NONE)
    else $error("invalid code armed a command");

  chk_write_clear: assert property (state_reg == ST_BUSY && cmd_reg == CODE_WRITE && flashDone
                                    |=> bufValid_reg == '0 && !cpuHalt)
    else $error("buffer survived page write");

  chk_lpm_read: assert property (state_reg == ST_ARMED && cmd_reg == CODE_LOCKSET && !ctrlWrite && !spmStrobe
                                 && lpmStrobe && !eepromBusy && armCnt_reg < LPM_WINDOW_CYC
                                 |=> lpmValid && cmd_reg == CODE_NONE)
    else $error("fuse or lock readback missing");

  chk_eeprom_block: assert property (state_reg == ST_IDLE && ctrlWrite && eepromBusy |=> state_reg == ST_IDLE)
    else $error("command armed during eeprom write");

  chk_reset_vec: assert property ($stable(bootVectorFuse) && !bootVectorFuse |=> resetVector == BOOT_START_WORD)
    else $error("boot vector not selected");

endmodule : flash_self_program_control

// ### hdl/flash_self_program_pkg.sv
// Purpose: Shared constants for the flash self-programming controller
// Assumes: 8-bit control register reached over a 32-bit APB word
// Notes: Command codes occupy the low five control bits

package flash_self_program_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ----------------------------------------
  // Control field positions
  // ----------------------------------------
  localparam int IE_BIT = 7;
  localparam int BUSY_BIT = 6;
  localparam int RES_BIT = 5;
  localparam int REEN_BIT = 4;
  localparam int LOCK_BIT = 3;
  localparam int WR_BIT = 2;
  localparam int ER_BIT = 1;
  localparam int EN_BIT = 0;

  // ----------------------------------------
  // Command codes
  // ----------------------------------------
  localparam logic [4:0] CODE_NONE = 5'h00;
  localparam logic [4:0] CODE_REENABLE = 5'h11;
  localparam logic [4:0] CODE_LOCKSET = 5'h09;
  localparam logic [4:0] CODE_WRITE = 5'h05;
  localparam logic [4:0] CODE_ERASE = 5'h03;
  localparam logic [4:0] CODE_LOAD = 5'h01;

  // ----------------------------------------
  // Timing in clock cycles
  // ----------------------------------------
  localparam logic [2:0] ARM_WINDOW_CYC = 3'h4;
  localparam logic [2:0] LPM_WINDOW_CYC = 3'h3;

  // ----------------------------------------
  // Values
  // ----------------------------------------
  localparam logic [15:0] APP_RESET_VECTOR = 16'h0000;
  localparam logic [15:0] ERASED_WORD = 16'hffff;
  localparam logic [1:0] ZSEL_FUSE_LOW = 2'h0;
  localparam logic [1:0] ZSEL_LOCK = 2'h1;
  localparam logic [1:0] ZSEL_FUSE_EXT = 2'h2;
  localparam logic [1:0] ZSEL_FUSE_HIGH = 2'h3;

  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_BUSY} seq_state_t;

endpackage : flash_self_program_pkg

// ### test/flash_macro_model.sv
// Purpose: Flash array stand-in answering erase, write and lock jobs
// Assumes: Jobs arrive as one-cycle pulses on clk_sys
// Notes: The bench sets the latency, so answers come promptly or slowly
`timescale 1ns/1ns
module flash_macro_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Jobs and answer
  input wire logic flashErase,
  input wire logic flashWrite,
  input wire logic lockProgram,
  input wire logic [7:0] latency,
  output logic flashDone
);
  // ----------------------------------------
  // Job timer
  // ----------------------------------------
  int cnt = 0;
  always @(posedge clk_sys) begin
    flashDone <= 1'b0;
    if (srst) begin
      cnt <= 0;
    end else if (flashErase || flashWrite || lockProgram) begin
      cnt <= int'(latency);
    end else if (cnt == 1) begin
      cnt <= 0;
      flashDone <= 1'b1;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule : flash_macro_model

// ### test/test_flash_self_program_control.sv
// Purpose: Self-checking bench for the flash self-programming controller
// Assumes: Zero-wait APB slave, flash answers from flash_macro_model
// Notes: Control and buffer expectations come from a small bench model
`timescale 1ns/1ns
module test_flash_self_program_control import flash_self_program_pkg::*;;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam logic [15:0] BOOTW = 16'h1c00;
  localparam int RWWP = 224;
  logic clk_sys = 1'b0;
  logic srst, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr, lpmData, fuseLow, fuseHigh, fuseExt, lockBits, lockData, latency;
  logic [31:0] pwdata, prdata, rd, e;
  logic spmStrobe, lpmStrobe, globalIntEnable, lpmValid, cpuHalt, readyIrq, sectionBusy;
  logic bootVectorFuse, lockProgram, eepromBusy, flashDone, flashErase, flashWrite;
  logic [15:0] zPointer, wordData, resetVector, bufReadData, v;
  logic [8:0] flashPage;
  logic [5:0] bufReadAddr;
  logic [7:0] fz[4];
  int n_mismatch = 0;
  int comparisons = 0;
  int mbusy, mbuf[64];
  always #25 clk_sys = ~clk_sys;
  flash_self_program_control #(.RWW_PAGE_COUNT(RWWP), .BOOT_START_WORD(BOOTW)) i_dut (.clk_sys, .srst, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .spmStrobe, .lpmStrobe, .zPointer, .wordData,
    .globalIntEnable, .lpmData, .lpmValid, .cpuHalt, .readyIrq, .sectionBusy, .resetVector, .bootVectorFuse,
    .fuseLow, .fuseHigh, .fuseExt, .lockBits, .lockProgram, .lockData, .eepromBusy, .flashDone, .flashErase,
    .flashWrite, .flashPage, .bufReadAddr, .bufReadData);
  flash_macro_model i_flash (.clk_sys, .srst, .flashErase, .flashWrite, .lockProgram, .latency, .flashDone);
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int i;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      n_mismatch++;
      end_of_test();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] d);
    apb(1'b1, CTRL_OFFSET, d);
  endtask : wr
  task automatic rdc(input logic [7:0] x);
    apb(1'b0, CTRL_OFFSET, 8'h00);
    chk(rd, {24'h0, x});
  endtask : rdc
  task automatic clr();
    foreach (mbuf[i]) mbuf[i] = 'hffff;
  endtask : clr
  task automatic rst();
    srst <= 1'b1;
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    clr();
    mbusy = 0;
    repeat (2) @(posedge clk_sys);
  endtask : rst
  task automatic store_program_instruction(input int d, input logic [15:0] z);
    repeat (d - 1) @(posedge clk_sys);
    zPointer <= z;
    spmStrobe <= 1'b1;
    @(posedge clk_sys);
    spmStrobe <= 1'b0;
  endtask : store_program_instruction
  task automatic lpm(input int d, input logic [15:0] z);
    repeat (d - 1) @(posedge clk_sys);
    zPointer <= z;
    lpmStrobe <= 1'b1;
    @(posedge clk_sys);
    lpmStrobe <= 1'b0;
    @(posedge clk_sys);
  endtask : lpm
  task automatic waitdone();
    int i;
    for (i = 0; i < 200; i++) begin
      @(posedge clk_sys);
      if (flashDone === 1'b1) break;
    end
    if (i == 200) begin
      n_mismatch++;
      end_of_test();
    end
    @(posedge clk_sys);
  endtask : waitdone
  task automatic load(input int d, input int w);
    logic [15:0] x;
    x = 16'($urandom);
    wordData <= x;
    wr(8'h01);
    store_program_instruction(d, {9'($urandom), w[5:0], 1'($urandom)});
    if (d <= 4) begin
      mbuf[w] = int'(x);
      mbusy = 0;
    end
    @(posedge clk_sys);
    chk(32'(sectionBusy), 32'(mbusy));
  endtask : load
  task automatic chkbuf();
    for (int w = 0; w < 64; w++) begin
      bufReadAddr <= 6'(w);
      @(posedge clk_sys);
      @(posedge clk_sys);
      chk(32'(bufReadData), mbuf[w]);
    end
  endtask : chkbuf
  task automatic op(input logic [4:0] c, input logic [15:0] z, input logic [7:0] lat);
    logic readable_while_write_section;
    readable_while_write_section = z[15:7] < 9'(RWWP);
    latency <= lat;
    wr({3'h0, c});
    store_program_instruction(1, z);
    zPointer <= ~z;
    @(posedge clk_sys);
    e = 32'({c == CODE_ERASE, c == CODE_WRITE, !readable_while_write_section, readable_while_write_section, z[15:7]});
    chk(32'({flashErase, flashWrite, cpuHalt, sectionBusy, flashPage}), e);
    if (readable_while_write_section) mbusy = 1;
    rdc({1'b0, 1'(mbusy), 1'b0, c});
    wr(8'h11);
    waitdone();
    rdc({1'b0, 1'(mbusy), 6'h0});
    chk(32'(flashPage), 32'(z[15:7]));
    chk(32'(cpuHalt), 0);
    if (c == CODE_WRITE) clr();
  endtask : op
  initial begin
    repeat (100000) @(posedge clk_sys);
    n_mismatch++;
    end_of_test();
  end
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    {srst, psel, penable, pwrite, spmStrobe, lpmStrobe, globalIntEnable, eepromBusy} = '0;
    {paddr, pwdata, zPointer, wordData, bufReadAddr} = '0;
    latency = 8'h01;
    bootVectorFuse = 1'b1;
    void'($urandom(32'h0628e957));
    {fuseLow, fuseHigh, fuseExt, lockBits} = $urandom;
    fz = '{fuseLow, lockBits, fuseExt, fuseHigh};
    rst();
    chk(32'(resetVector), 32'(APP_RESET_VECTOR));
    rdc(8'h00);
    apb(1'b1, 8'h04, 8'hff);
    chk(32'(er), 1);
    apb(1'b0, 8'h04, 8'h00);
    chk({rd[30:0], er}, 1);
    for (int c = 0; c < 32; c++) begin
      if (!(5'(c) inside {CODE_REENABLE, CODE_LOCKSET, CODE_WRITE, CODE_ERASE, CODE_LOAD})) begin
        wr(8'he0 | 8'(c));
        rdc(8'h80);
      end
    end
    $display("test register map done");
    globalIntEnable <= 1'b1;
    wr(8'h81);
    repeat (4) @(posedge clk_sys);
    chk(32'(readyIrq), 0);
    @(posedge clk_sys);
    chk(32'(readyIrq), 1);
    globalIntEnable <= 1'b0;
    wr(8'h00);
    repeat (2) @(posedge clk_sys);
    chk(32'(readyIrq), 0);
    $display("test ready interrupt done");
    for (int k = 0; k < 12; k++) load(k % 5 + 1, $urandom % 64);
    chkbuf();
    wr(8'h10);
    clr();
    chkbuf();
    $display("test buffer load done");
    v = {9'd5, 7'h5b};
    op(CODE_ERASE, v, 8'd12);
    load(1, 3);
    op(CODE_WRITE, v & 16'hff80, 8'd20);
    chkbuf();
    wr(8'h11);
    store_program_instruction(2, 16'h0000);
    mbusy = 0;
    rdc(8'h00);
    chk(32'(sectionBusy), 0);
    op(CODE_ERASE, {9'd300, 7'h00}, 8'd10);
    op(CODE_WRITE, {9'd300, 7'h00}, 8'd6);
    $display("test erase and write done");
    wordData <= 16'($urandom);
    wr(8'h09);
    store_program_instruction(3, 16'hffff);
    @(posedge clk_sys);
    chk(32'({lockProgram, lockData}), 32'({1'b1, wordData[7:0]}));
    waitdone();
    rdc(8'h00);
    for (int s = 0; s < 4; s++) begin
      wr(8'h09);
      lpm(s % 3 + 1, 16'(s));
      chk(32'({lpmValid, lpmData}), 32'({1'b1, fz[s]}));
      rdc(8'h00);
    end
    $display("test lock bits done");
    eepromBusy <= 1'b1;
    wr(8'h03);
    store_program_instruction(1, 16'h0000);
    @(posedge clk_sys);
    chk(32'(flashErase), 0);
    wr(8'h09);
    lpm(1, 16'h0001);
    chk(32'(lpmValid), 0);
    eepromBusy <= 1'b0;
    $display("test interlock done");
    load(1, 7);
    chk(32'(resetVector), 32'(APP_RESET_VECTOR));
    bootVectorFuse <= 1'b0;
    rst();
    chk(32'(resetVector), 32'(BOOTW));
    chkbuf();
    $display("test reset done");
    end_of_test();
  end
endmodule : test_flash_self_program_control
